// ### pkb_params.svh
`ifndef PKB_PARAMS_SVH
`define PKB_PARAMS_SVH
`define PKB_ADR_LATCH0 4'h0
`define PKB_ADR_LATCH1 4'h1
`define PKB_ADR_LATCH2 4'h2
`define PKB_ADR_MODEA0 4'h3
`define PKB_ADR_MODEB0 4'h4
`define PKB_ADR_MODEA1 4'h5
`define PKB_ADR_MODEB1 4'h6
`define PKB_ADR_MODEA2 4'h7
`define PKB_ADR_MODEB2 4'h8
`define PKB_ADR_KPEN 4'h9
`define PKB_ADR_KPCTL 4'ha
`define PKB_ADR_PIN0 4'hb
`define PKB_ADR_PIN1 4'hc
`define PKB_ADR_PIN2 4'hd
`define PKB_ADR_CFG 4'he
`define PKB_MA2_SCH0 2
`define PKB_MA2_SCH1 3
`define PKB_MA2_SCH2 4
`define PKB_MA2_T0OE 5
`define PKB_MA2_T1OE 6
`define PKB_MA2_CLKOE 7
`define PKB_KC_FLAG 0
`define PKB_KC_ACT 1
`define PKB_KC_IEN 2
`define PKB_CFG_RSTHI 0
`define PKB_CFG_INTRST 1
`define PKB_CFG_XTAL 2
`define PKB_FIX_OD_A 2
`define PKB_FIX_OD_B 3
`define PKB_RST_PIN 5
`define PKB_STRONG_NS 100
`define PKB_CLK_NS 50
`define PKB_STRONG_CYC ((`PKB_STRONG_NS + `PKB_CLK_NS - 1) / `PKB_CLK_NS)
`endif

// ### pkb_pkg.sv
package pkb_pkg;
	typedef enum logic [1:0] {
		PKB_QUASI = 2'b00,
		PKB_PUSHPULL = 2'b01,
		PKB_INPUT = 2'b10,
		PKB_OPENDRAIN = 2'b11
	} pkb_mode_t;
	typedef logic [7:0] pkb_byte_t;
endpackage

// ### pkb_port_kbi.sv
`timescale 1ns/1ps
`include "pkb_params.svh"
// Notes on behaviour
// - Two mode bits per pin: 00 quasi, 01 push-pull, 10 input, 11 open drain.
// - Mode chosen per pin; three fixed pins ignore mode bits.
// - Configurable pins come up quasi-bidirectional after reset.
// - Quasi mode: very weak pull-up on whenever latch holds one.
// - Quasi mode: weak pull-up on only while latch and pin are both one.
// - Quasi latch rising zero to one: strong pull-up for exactly two clocks.
// - Open drain: no pull-ups, pull-down only while latch is zero.
// - Push-pull: pull-down on zero, strong pull-up held on one.
// - Input only: everything off, pin high impedance.
// - Two fixed port-1 pins are always open drain; ones make them inputs.
// - Reset-shared pin is Schmitt input only with internal reset configured.
// - Oscillator pins of port 2 disabled both ways with crystal option.
// - Reset pin level follows reset-level bit; high-reset pins are quasi.
// - One bit per port picks TTL or Schmitt; fixed pins always Schmitt.
// - Spare port-2 mode-A bits hold Schmitt, timer toggle, clock-out enables.
// - Each port-0 pin has its own keypad enable bit.
// - Keypad flag sets when any enabled port-0 pin is low while active.
// - Interrupt requested while flag set only if keypad interrupt enabled.
// - Flag stays set until software clears it; hardware never clears.
// - Keypad request can wake CPU from Idle and Power Down.
module pkb_port_kbi
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic CFG_RESET_HIGH,
	input wire logic CFG_INTERNAL_RESET,
	input wire logic CFG_CRYSTAL_OSC,
	input wire logic [23:0] PIN_I,
	output logic [23:0] PIN_VWEAK_O,
	output logic [23:0] PIN_WEAK_O,
	output logic [23:0] PIN_STRONG_O,
	output logic [23:0] PIN_PULLDOWN_O,
	output logic [23:0] PIN_OE_N,
	output logic [2:0] SCHMITT_EN_O,
	output logic TIMER0_TOGGLE_EN_O,
	output logic TIMER1_TOGGLE_EN_O,
	output logic CLKOUT_EN_O,
	output logic KEYPAD_IRQ_O,
	output logic WAKE_O
);
	import pkb_pkg::*;

	localparam int STRONG_CYC = `PKB_STRONG_CYC;

	logic [23:0] latch_reg;
	logic [23:0] mode_a_reg;
	logic [23:0] mode_b_reg;
	logic [23:0] latch_prev_reg;
	logic [23:0] sync1_reg;
	logic [23:0] sync2_reg;
	logic [23:0] strong_pulse_reg;
	logic [1:0] strong_cnt_reg [23:0];
	logic [7:0] kp_en_reg;
	logic kp_flag_reg;
	logic kp_act_reg;
	logic kp_ien_reg;
	logic rst_hi_reg;
	logic int_rst_reg;
	logic xtal_reg;
	logic strap_done_reg;
	logic level_done_reg;
	logic [23:0] vweak_next;
	logic [23:0] weak_next;
	logic [23:0] strong_next;
	logic [23:0] pd_next;
	logic [23:0] oe_n_next;
	logic [23:0] disabled_pins;
	logic [23:0] pin_seen;
	logic [31:0] rd_data;
	logic wr_en;
	logic kp_hit;
	logic kp_clr;

	assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];

	// Straps caught after reset release
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			strap_done_reg <= 1'b0;
			rst_hi_reg <= 1'b1;
			int_rst_reg <= 1'b0;
			xtal_reg <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			rst_hi_reg <= CFG_RESET_HIGH;
			int_rst_reg <= CFG_INTERNAL_RESET;
			xtal_reg <= CFG_CRYSTAL_OSC;
		end
	end

	// Latches take the strapped reset level once, at the second edge
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			level_done_reg <= 1'b0;
		else if (strap_done_reg)
			level_done_reg <= 1'b1;
	end

	// Pin synchroniser
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_reg <= 24'h0;
			sync2_reg <= 24'h0;
		end
		else
		begin
			sync1_reg <= PIN_I;
			sync2_reg <= sync1_reg;
		end
	end

	// Port latches and mode registers
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			latch_reg <= 24'hffffff;
			mode_a_reg <= 24'h0;
			mode_b_reg <= 24'h0;
		end
		else if (strap_done_reg && !level_done_reg)
			latch_reg <= rst_hi_reg ? 24'hffffff : 24'h0;
		else if (wr_en)
		begin
			unique case (WB_ADR_I)
				`PKB_ADR_LATCH0: latch_reg[7:0] <= WB_DAT_I[7:0];
				`PKB_ADR_LATCH1: latch_reg[15:8] <= WB_DAT_I[7:0];
				`PKB_ADR_LATCH2: latch_reg[23:16] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEA0: mode_a_reg[7:0] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEB0: mode_b_reg[7:0] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEA1: mode_a_reg[15:8] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEB1: mode_b_reg[15:8] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEA2: mode_a_reg[23:16] <= WB_DAT_I[7:0];
				`PKB_ADR_MODEB2: mode_b_reg[23:16] <= WB_DAT_I[7:0];
				default: ;
			endcase
		end
	end

	// Pins lost to the crystal or the reset function
	always_comb
	begin
		disabled_pins = 24'h0;
		// Port 2 bonds out only its two oscillator pins
		disabled_pins[23:18] = 6'h3f;
		if (xtal_reg)
		begin
			disabled_pins[16] = 1'b1;
			disabled_pins[17] = 1'b1;
		end
		if (!int_rst_reg)
			disabled_pins[8 + `PKB_RST_PIN] = 1'b1;
	end

	assign pin_seen = sync2_reg & ~disabled_pins;

	// Strong pull-up pulse timers
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			latch_prev_reg <= 24'hffffff;
		else
			latch_prev_reg <= latch_reg;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 24; gi++)
		begin : g_pin
			always_ff @(posedge CLOCK or negedge RST_N)
			begin
				if (!RST_N)
					strong_cnt_reg[gi] <= 2'h0;
				else if (latch_reg[gi] && !latch_prev_reg[gi])
					strong_cnt_reg[gi] <= 2'(STRONG_CYC);
				else if (strong_cnt_reg[gi] != 2'h0)
					strong_cnt_reg[gi] <= strong_cnt_reg[gi] - 2'h1;
			end
			assign strong_pulse_reg[gi] = strong_cnt_reg[gi] != 2'h0;
		end
	endgenerate

	// Driver decode per pin
	always_comb
	begin
		pkb_mode_t m;
		m = PKB_QUASI;
		vweak_next = 24'h0;
		weak_next = 24'h0;
		strong_next = 24'h0;
		pd_next = 24'h0;
		oe_n_next = 24'hffffff;
		for (int i = 0; i < 24; i++)
		begin
			m = pkb_mode_t'({mode_a_reg[i], mode_b_reg[i]});
			if (!strap_done_reg)
				m = PKB_QUASI;
			if (i == 8 + `PKB_FIX_OD_A || i == 8 + `PKB_FIX_OD_B)
				m = PKB_OPENDRAIN;
			if (i == 8 + `PKB_RST_PIN)
				m = PKB_INPUT;
			unique case (m)
				PKB_QUASI:
				begin
					vweak_next[i] = latch_reg[i];
					weak_next[i] = latch_reg[i] && sync2_reg[i];
					strong_next[i] = latch_reg[i] && strong_pulse_reg[i];
					pd_next[i] = !latch_reg[i];
				end
				PKB_PUSHPULL:
				begin
					strong_next[i] = latch_reg[i];
					pd_next[i] = !latch_reg[i];
				end
				PKB_OPENDRAIN: pd_next[i] = !latch_reg[i];
				PKB_INPUT: ;
			endcase
			if (disabled_pins[i] && i != 8 + `PKB_RST_PIN)
			begin
				vweak_next[i] = 1'b0;
				weak_next[i] = 1'b0;
				strong_next[i] = 1'b0;
				pd_next[i] = 1'b0;
			end
			oe_n_next[i] = !(strong_next[i] || pd_next[i]);
		end
	end

	// Registered driver enables
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PIN_VWEAK_O <= 24'hffffff;
			PIN_WEAK_O <= 24'h0;
			PIN_STRONG_O <= 24'h0;
			PIN_PULLDOWN_O <= 24'h0;
			PIN_OE_N <= 24'hffffff;
		end
		else
		begin
			PIN_VWEAK_O <= vweak_next;
			PIN_WEAK_O <= weak_next;
			PIN_STRONG_O <= strong_next;
			PIN_PULLDOWN_O <= pd_next;
			PIN_OE_N <= oe_n_next;
		end
	end

	// Side enables from port-2 mode register A
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SCHMITT_EN_O <= 3'h0;
			TIMER0_TOGGLE_EN_O <= 1'b0;
			TIMER1_TOGGLE_EN_O <= 1'b0;
			CLKOUT_EN_O <= 1'b0;
		end
		else
		begin
			SCHMITT_EN_O <= {mode_a_reg[16 + `PKB_MA2_SCH2], mode_a_reg[16 + `PKB_MA2_SCH1],
				mode_a_reg[16 + `PKB_MA2_SCH0]};
			TIMER0_TOGGLE_EN_O <= mode_a_reg[16 + `PKB_MA2_T0OE];
			TIMER1_TOGGLE_EN_O <= mode_a_reg[16 + `PKB_MA2_T1OE];
			CLKOUT_EN_O <= mode_a_reg[16 + `PKB_MA2_CLKOE] && !xtal_reg;
		end
	end

	// Keypad logic
	assign kp_hit = kp_act_reg && ((~pin_seen[7:0] & kp_en_reg) != 8'h0);
	assign kp_clr = wr_en && WB_ADR_I == `PKB_ADR_KPCTL && !WB_DAT_I[`PKB_KC_FLAG];

	// Keypad enables and control bits
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			kp_en_reg <= 8'h0;
			kp_act_reg <= 1'b0;
			kp_ien_reg <= 1'b0;
		end
		else if (wr_en && WB_ADR_I == `PKB_ADR_KPEN)
			kp_en_reg <= WB_DAT_I[7:0];
		else if (wr_en && WB_ADR_I == `PKB_ADR_KPCTL)
		begin
			kp_act_reg <= WB_DAT_I[`PKB_KC_ACT];
			kp_ien_reg <= WB_DAT_I[`PKB_KC_IEN];
		end
	end

	// Sticky flag, a set beats a clear in the same cycle
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			kp_flag_reg <= 1'b0;
		else if (kp_hit)
			kp_flag_reg <= 1'b1;
		else if (kp_clr)
			kp_flag_reg <= 1'b0;
	end

	// Request and wake follow flag and enable
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			KEYPAD_IRQ_O <= 1'b0;
			WAKE_O <= 1'b0;
		end
		else
		begin
			KEYPAD_IRQ_O <= kp_flag_reg && kp_ien_reg;
			WAKE_O <= kp_flag_reg && kp_ien_reg;
		end
	end

	// Register read mux
	always_comb
	begin
		rd_data = 32'h0;
		unique case (WB_ADR_I)
			`PKB_ADR_LATCH0: rd_data[7:0] = latch_reg[7:0];
			`PKB_ADR_LATCH1: rd_data[7:0] = latch_reg[15:8];
			`PKB_ADR_LATCH2: rd_data[7:0] = latch_reg[23:16];
			`PKB_ADR_MODEA0: rd_data[7:0] = mode_a_reg[7:0];
			`PKB_ADR_MODEB0: rd_data[7:0] = mode_b_reg[7:0];
			`PKB_ADR_MODEA1: rd_data[7:0] = mode_a_reg[15:8];
			`PKB_ADR_MODEB1: rd_data[7:0] = mode_b_reg[15:8];
			`PKB_ADR_MODEA2: rd_data[7:0] = mode_a_reg[23:16];
			`PKB_ADR_MODEB2: rd_data[7:0] = mode_b_reg[23:16];
			`PKB_ADR_KPEN: rd_data[7:0] = kp_en_reg;
			`PKB_ADR_KPCTL: rd_data[2:0] = {kp_ien_reg, kp_act_reg, kp_flag_reg};
			`PKB_ADR_PIN0: rd_data[7:0] = pin_seen[7:0];
			`PKB_ADR_PIN1: rd_data[7:0] = pin_seen[15:8];
			`PKB_ADR_PIN2: rd_data[7:0] = pin_seen[23:16];
			`PKB_ADR_CFG: rd_data[2:0] = {xtal_reg, int_rst_reg, rst_hi_reg};
			default: rd_data = 32'h0;
		endcase
	end

	// Bus answer one cycle after the request
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
		end
		else
		begin
			WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
			WB_DAT_O <= rd_data;
		end
	end
endmodule

// ### pkb_pin_model.sv
`timescale 1ns/1ps
module pkb_pin_model
(
	input wire logic [23:0] pull_dn,
	input wire logic [23:0] ext_low,
	output logic [23:0] level
);
	// Board resistors hold free pins high, keys short them low
	assign level = ~(pull_dn | ext_low);
endmodule

// ### pkb_port_kbi_props.sv
`timescale 1ns/1ps
module pkb_port_kbi_props
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_WE_I,
	input wire logic CFG_CRYSTAL_OSC,
	input wire logic [23:0] PIN_VWEAK_O,
	input wire logic [23:0] PIN_WEAK_O,
	input wire logic [23:0] PIN_STRONG_O,
	input wire logic [23:0] PIN_PULLDOWN_O,
	input wire logic [23:0] PIN_OE_N,
	input wire logic KEYPAD_IRQ_O,
	input wire logic WAKE_O
);
	logic [1:0] up_reg;
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	a_strong_two_clk: assert property ($rose(PIN_STRONG_O[0]) && PIN_VWEAK_O[0] |=> PIN_STRONG_O[0] ##1 !PIN_STRONG_O[0])
		else $error("strong pulse length");
	a_fixed_no_pullup: assert property (up_reg == 2'h3 |-> ((PIN_VWEAK_O | PIN_WEAK_O | PIN_STRONG_O) & 24'h002c00) == 24'h0)
		else $error("fixed pin pull-up on");
	a_weak_needs_latch: assert property ((PIN_WEAK_O & ~PIN_VWEAK_O) == 24'h0)
		else $error("weak without very weak");
	a_pulldown_alone: assert property ((PIN_PULLDOWN_O & (PIN_VWEAK_O | PIN_WEAK_O | PIN_STRONG_O)) == 24'h0)
		else $error("pull-down with pull-up");
	a_oe_tracks_drive: assert property (PIN_OE_N == ~(PIN_STRONG_O | PIN_PULLDOWN_O))
		else $error("enable mismatch");
	a_wake_follows: assert property (WAKE_O == KEYPAD_IRQ_O)
		else $error("wake differs");
	a_flag_sticky: assert property (KEYPAD_IRQ_O && !WB_WE_I && !$past(WB_WE_I) && !$past(WB_WE_I, 2) |=> KEYPAD_IRQ_O)
		else $error("request dropped");
	a_xtal_pins_off: assert property (CFG_CRYSTAL_OSC && up_reg == 2'h3 |-> ((PIN_VWEAK_O | PIN_WEAK_O | PIN_STRONG_O | PIN_PULLDOWN_O) & 24'h030000) == 24'h0)
		else $error("oscillator pin driven");
endmodule
bind pkb_port_kbi pkb_port_kbi_props u_props
(
	.CLOCK(CLOCK), .RST_N(RST_N), .WB_WE_I(WB_WE_I), .CFG_CRYSTAL_OSC(CFG_CRYSTAL_OSC),
	.PIN_VWEAK_O(PIN_VWEAK_O), .PIN_WEAK_O(PIN_WEAK_O), .PIN_STRONG_O(PIN_STRONG_O),
	.PIN_PULLDOWN_O(PIN_PULLDOWN_O), .PIN_OE_N(PIN_OE_N), .KEYPAD_IRQ_O(KEYPAD_IRQ_O), .WAKE_O(WAKE_O)
);

// ### pkb_port_kbi_bench.sv
`timescale 1ns/1ps
`include "pkb_params.svh"
module pkb_port_kbi_bench;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic xtal = 1'b0;
	logic rsthi = 1'b1;
	logic intrst = 1'b1;
	logic [23:0] oe;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd, dat_o;
	logic [23:0] ext_low = 24'h0;
	logic [23:0] lvl, vw, wk, st, pd;
	logic [2:0] sch;
	logic ack, t0, t1, ck, irq, wake;
	int bad_count = 0;
	int check_count = 0;
	int cyc_count = 0;
	pkb_port_kbi DUT
	(
		.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_DAT_I(wdat), .WB_SEL_I(4'hf), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CFG_RESET_HIGH(rsthi),
		.CFG_INTERNAL_RESET(intrst), .CFG_CRYSTAL_OSC(xtal), .PIN_I(lvl), .PIN_VWEAK_O(vw), .PIN_WEAK_O(wk),
		.PIN_STRONG_O(st), .PIN_PULLDOWN_O(pd), .PIN_OE_N(oe), .SCHMITT_EN_O(sch), .TIMER0_TOGGLE_EN_O(t0),
		.TIMER1_TOGGLE_EN_O(t1), .CLKOUT_EN_O(ck), .KEYPAD_IRQ_O(irq), .WAKE_O(wake)
	);
	pkb_pin_model u_pins (.pull_dn(pd), .ext_low(ext_low), .level(lvl));
	initial
	begin
		forever #25 CLOCK = ~CLOCK;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge CLOCK)
	begin
		cyc_count++;
		if (cyc_count == 3000)
		begin
			bad_count++;
			stop_test;
		end
	end
	task wbx(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		{req, we, adr, wdat} <= {1'b1, w, a, 24'h0, d};
		do @(posedge CLOCK); while (ack !== 1'b1);
		rd = dat_o;
		{req, we} <= 2'b00;
		@(posedge CLOCK);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge CLOCK);
		@(negedge CLOCK);
	endtask
	task pins(input logic [23:0] v);
		@(posedge CLOCK);
		ext_low <= v;
	endtask
	initial
	begin
		int n;
		repeat (12) @(posedge CLOCK);
		RST_N <= 1'b1;
		idle(4);
		chk("vweak", 24'h03d3ff, vw);
		wbx(1, `PKB_ADR_LATCH1, 8'h00);
		idle(2);
		chk("pd1", 8'hdf, pd[15:8]);
		wbx(1, `PKB_ADR_MODEB1, 8'hff);
		wbx(1, `PKB_ADR_LATCH1, 8'hff);
		idle(3);
		chk("st1", 8'hd3, st[15:8]);
		wbx(0, `PKB_ADR_PIN1, 8'h00);
		chk("pin1", 8'hff, rd[7:0]);
		$display("fixed pins done");
		for (int m = 0; m < 4; m++)
		begin
			wbx(1, `PKB_ADR_MODEA0, {7'h0, m[1]});
			wbx(1, `PKB_ADR_MODEB0, {7'h0, m[0]});
			wbx(1, `PKB_ADR_LATCH0, 8'h00);
			idle(2);
			chk("pd0", m != 2, pd[0]);
			wbx(1, `PKB_ADR_LATCH0, 8'h01);
			n = 0;
			repeat (6)
			begin
				@(negedge CLOCK);
				n += st[0];
			end
			chk("strong", (m == 0) ? 2 : ((m == 1) ? 6 : 0), n);
			chk("vweak0", m == 0, vw[0]);
			chk("weak0", m == 0, wk[0]);
			chk("oe0", m != 1, oe[0]);
		end
		wbx(1, `PKB_ADR_MODEA0, 8'h00);
		wbx(1, `PKB_ADR_MODEB0, 8'h00);
		pins(24'h000001);
		idle(5);
		chk("weak low", 2'b01, {wk[0], vw[0]});
		$display("modes done");
		wbx(1, `PKB_ADR_LATCH0, 8'hff);
		wbx(1, `PKB_ADR_KPEN, 8'h08);
		wbx(1, `PKB_ADR_KPCTL, 8'h02);
		pins(24'h000004);
		idle(6);
		wbx(0, `PKB_ADR_KPCTL, 8'h00);
		chk("flag off", 8'h02, rd[7:0]);
		pins(24'h000008);
		idle(6);
		wbx(0, `PKB_ADR_KPCTL, 8'h00);
		chk("flag on", 8'h03, rd[7:0]);
		chk("irq off", 1'b0, irq);
		pins(24'h000000);
		wbx(1, `PKB_ADR_KPCTL, 8'h07);
		idle(3);
		chk("irq", 2'b11, {irq, wake});
		idle(10);
		wbx(0, `PKB_ADR_KPCTL, 8'h00);
		chk("flag kept", 8'h07, rd[7:0]);
		wbx(1, `PKB_ADR_KPCTL, 8'h06);
		idle(3);
		chk("irq clr", 1'b0, irq);
		$display("keypad done");
		wbx(1, `PKB_ADR_MODEA2, 8'hfc);
		idle(2);
		chk("aux", 6'h3f, {ck, t1, t0, sch});
		wbx(0, 4'hf, 8'h00);
		chk("unmapped", 32'h0, rd);
		$display("config done");
		@(posedge CLOCK);
		{RST_N, xtal, rsthi, intrst} <= 4'b0100;
		repeat (12) @(posedge CLOCK);
		RST_N <= 1'b1;
		idle(4);
		chk("xtal drv", 8'h00, {vw[17:16], wk[17:16], st[17:16], pd[17:16]});
		wbx(0, `PKB_ADR_PIN2, 8'h00);
		chk("xtal rd", 2'b00, rd[1:0]);
		chk("rst low", 8'hff, pd[7:0]);
		wbx(0, `PKB_ADR_LATCH0, 8'h00);
		chk("latch low", 8'h00, rd[7:0]);
		wbx(0, `PKB_ADR_PIN1, 8'h00);
		chk("pin1 off", 8'h00, rd[7:0]);
		wbx(0, `PKB_ADR_CFG, 8'h00);
		chk("straps", 3'h4, rd[2:0]);
		$display("crystal done");
		stop_test;
	end
endmodule
